// file: rtl/fault_timing_pkg.sv
// Package of offsets, field layouts, reset values and timing figures
// Assumes a 50 MHz core clock; all cycle counts derive from CLK_HZ
package fault_timing_pkg;

	localparam int CLK_HZ = 50_000_000;

	// Register offsets on the serial register link
	localparam logic [7:0] REG_OC_TIMING = 8'h13;
	localparam logic [7:0] REG_RETRY_TIMING = 8'h16;
	localparam logic [7:0] REG_FAULT_CLEAR = 8'h17;
	localparam logic [7:0] REG_GEN_PERIOD = 8'h18;
	localparam logic [7:0] REG_DUTY_A = 8'h19;
	localparam logic [7:0] REG_DUTY_B = 8'h1a;
	localparam logic [7:0] REG_DUTY_C = 8'h1b;

	// Reset values
	localparam logic [15:0] RST_OC_TIMING = 16'h0030;
	localparam logic [15:0] RST_RETRY_TIMING = 16'h0003;
	localparam logic [15:0] RST_FAULT_CLEAR = 16'h0000;
	localparam logic [15:0] RST_GEN_VALUE = 16'h0000;

	// Field positions
	localparam int PARITY_POS = 15;
	localparam int FILTER_LSB = 4;
	localparam int MASK_LSB = 2;
	localparam int THRESH_POS = 0;
	localparam int LONG_LSB = 2;
	localparam int SHORT_LSB = 0;
	localparam int WIPE_POS = 0;
	localparam int VALUE_W = 12;

	// Overcurrent response codes
	localparam logic [2:0] RESP_LONG = 3'h0;
	localparam logic [2:0] RESP_SHORT = 3'h1;
	localparam logic [2:0] RESP_LATCH = 3'h2;
	localparam logic [2:0] RESP_REPORT = 3'h3;
	localparam logic [2:0] RESP_OFF = 3'h7;

	// Filter and masking times in ns, shared table
	localparam int QUAL_NS_0 = 200;
	localparam int QUAL_NS_1 = 500;
	localparam int QUAL_NS_2 = 800;
	localparam int QUAL_NS_3 = 1000;
	// Least times: round up
	localparam int QUAL_C0 = (QUAL_NS_0 * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int QUAL_C1 = (QUAL_NS_1 * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int QUAL_C2 = (QUAL_NS_2 * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int QUAL_C3 = (QUAL_NS_3 * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int QUAL_W = 6;

	// Retry times: short in us, long in ms
	localparam int SHORT_US_0 = 500;
	localparam int SHORT_US_1 = 1000;
	localparam int SHORT_US_2 = 2000;
	localparam int SHORT_US_3 = 5000;
	localparam int LONG_MS_0 = 500;
	localparam int LONG_MS_1 = 1000;
	localparam int LONG_MS_2 = 2000;
	localparam int LONG_MS_3 = 5000;
	localparam int SHORT_C0 = SHORT_US_0 * (CLK_HZ / 1_000_000);
	localparam int SHORT_C1 = SHORT_US_1 * (CLK_HZ / 1_000_000);
	localparam int SHORT_C2 = SHORT_US_2 * (CLK_HZ / 1_000_000);
	localparam int SHORT_C3 = SHORT_US_3 * (CLK_HZ / 1_000_000);
	localparam int LONG_C0 = LONG_MS_0 * (CLK_HZ / 1000);
	localparam int LONG_C1 = LONG_MS_1 * (CLK_HZ / 1000);
	localparam int LONG_C2 = LONG_MS_2 * (CLK_HZ / 1000);
	localparam int LONG_C3 = LONG_MS_3 * (CLK_HZ / 1000);
	localparam int RETRY_W = 32;

	// Decoded qualifier time for a two-bit code
	function automatic logic [QUAL_W-1:0] qual_cycles(input logic [1:0] code);
		case (code)
			2'h0: qual_cycles = QUAL_W'(QUAL_C0);
			2'h1: qual_cycles = QUAL_W'(QUAL_C1);
			2'h2: qual_cycles = QUAL_W'(QUAL_C2);
			default: qual_cycles = QUAL_W'(QUAL_C3);
		endcase
	endfunction

	typedef enum {FS_RUN, FS_RETRY, FS_LATCHED} fault_state_e;

	// Generator settings handed to the PWM engine
	typedef struct packed {
		logic threshold_low;
		logic [VALUE_W-1:0] period;
		logic [VALUE_W-1:0] duty_a;
		logic [VALUE_W-1:0] duty_b;
		logic [VALUE_W-1:0] duty_c;
	} gen_cfg_s;

endpackage

// file: rtl/fault_timing_regs.sv
// Fault timing and PWM generator register bank with fault sequencer
// Operation
// - Bit 15 carries parity when checking enabled
// - Filter field sets overcurrent persistence time
// - Mask field sets blanking interval after edges
// - Threshold bit picks 9 A or 5 A
// - Long field selects slow retry delay
// - Short field selects fast retry delay
// - Writing one wipes all latched fault bits
// - Wipe bit returns to zero by itself
// - Writing zero to wipe changes nothing
// - Twelve-bit generator period, reset zero
// - Twelve-bit phase A duty, reset zero
// - Twelve-bit phase B duty value
// - Twelve-bit phase C duty value
// - Response mode picks retry, latch, report
// Assumes the serial front end delivers whole 16-bit words on clk
`timescale 1ns/1ps
module fault_timing_regs
	import fault_timing_pkg::*;
#(
	parameter int unsigned LONG_RETRY_C0 = LONG_C0,
	parameter int unsigned LONG_RETRY_C1 = LONG_C1,
	parameter int unsigned LONG_RETRY_C2 = LONG_C2,
	parameter int unsigned LONG_RETRY_C3 = LONG_C3,
	parameter int unsigned SHORT_RETRY_C0 = SHORT_C0,
	parameter int unsigned SHORT_RETRY_C1 = SHORT_C1,
	parameter int unsigned SHORT_RETRY_C2 = SHORT_C2,
	parameter int unsigned SHORT_RETRY_C3 = SHORT_C3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register word port from the serial link
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic link_parity_error,
	// Device-level settings
	input wire logic link_check_enable,
	input wire logic [2:0] overcurrent_response_sel,
	// Overcurrent sensing
	input wire logic oc_level_raw,
	input wire logic switch_edge,
	// Driver and fault outputs
	output gen_cfg_s gen_cfg,
	output logic outputs_hiz,
	output logic fault_indicator_pin_n,
	output logic oc_fault_status
);

	logic [1:0] overcurrent_filter_sel;
	logic [1:0] overcurrent_mask_sel;
	logic overcurrent_threshold_sel;
	logic [1:0] long_recovery_interval;
	logic [1:0] short_recovery_interval;
	logic latched_fault_wipe;
	logic [VALUE_W-1:0] generator_period_value;
	logic [VALUE_W-1:0] phase_a_duty_value;
	logic [VALUE_W-1:0] phase_b_duty_value;
	logic [VALUE_W-1:0] phase_c_duty_value;

	logic wr_ok, wr_bad, oc_detect, blanking;
	logic timer_start, timer_abort, timer_expired, timer_busy;
	logic [RETRY_W-1:0] retry_load;
	fault_state_e state, next_state;
	logic [15:0] next_rdata;

	// Even parity over the lower fifteen bits
	function automatic logic word_parity(input logic [15:0] w);
		word_parity = ^w[PARITY_POS-1:0];
	endfunction

	// Attach the parity bit on the way out
	function automatic logic [15:0] seal(input logic [15:0] w, input logic en);
		seal = w;
		seal[PARITY_POS] = en ? word_parity(w) : 1'b0;
	endfunction

	// Write accepted unless parity checking rejects it
	assign wr_bad = reg_wr && link_check_enable
		&& (reg_wdata[PARITY_POS] != word_parity(reg_wdata));
	assign wr_ok = reg_wr && !wr_bad;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			link_parity_error <= 1'b0;
		else
			link_parity_error <= wr_bad;
	end

	// Overcurrent timing configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overcurrent_filter_sel <= RST_OC_TIMING[FILTER_LSB +: 2];
			overcurrent_mask_sel <= RST_OC_TIMING[MASK_LSB +: 2];
			overcurrent_threshold_sel <= RST_OC_TIMING[THRESH_POS];
		end else if (wr_ok && reg_addr == REG_OC_TIMING) begin
			overcurrent_filter_sel <= reg_wdata[FILTER_LSB +: 2];
			overcurrent_mask_sel <= reg_wdata[MASK_LSB +: 2];
			overcurrent_threshold_sel <= reg_wdata[THRESH_POS];
		end
	end

	// Retry timing configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			long_recovery_interval <= RST_RETRY_TIMING[LONG_LSB +: 2];
			short_recovery_interval <= RST_RETRY_TIMING[SHORT_LSB +: 2];
		end else if (wr_ok && reg_addr == REG_RETRY_TIMING) begin
			long_recovery_interval <= reg_wdata[LONG_LSB +: 2];
			short_recovery_interval <= reg_wdata[SHORT_LSB +: 2];
		end
	end

	// Wipe command lives for one cycle only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			latched_fault_wipe <= RST_FAULT_CLEAR[WIPE_POS];
		else
			latched_fault_wipe <= wr_ok && reg_addr == REG_FAULT_CLEAR
				&& reg_wdata[WIPE_POS];
	end

	// Generator period and duty values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			generator_period_value <= RST_GEN_VALUE[VALUE_W-1:0];
			phase_a_duty_value <= RST_GEN_VALUE[VALUE_W-1:0];
			phase_b_duty_value <= RST_GEN_VALUE[VALUE_W-1:0];
			phase_c_duty_value <= RST_GEN_VALUE[VALUE_W-1:0];
		end else if (wr_ok) begin
			case (reg_addr)
				REG_GEN_PERIOD: generator_period_value <= reg_wdata[VALUE_W-1:0];
				REG_DUTY_A: phase_a_duty_value <= reg_wdata[VALUE_W-1:0];
				REG_DUTY_B: phase_b_duty_value <= reg_wdata[VALUE_W-1:0];
				REG_DUTY_C: phase_c_duty_value <= reg_wdata[VALUE_W-1:0];
				default: ;
			endcase
		end
	end

	assign gen_cfg.threshold_low = overcurrent_threshold_sel;
	assign gen_cfg.period = generator_period_value;
	assign gen_cfg.duty_a = phase_a_duty_value;
	assign gen_cfg.duty_b = phase_b_duty_value;
	assign gen_cfg.duty_c = phase_c_duty_value;

	// Read mux; wipe bit always reads zero
	always_comb begin
		next_rdata = '0;
		case (reg_addr)
			REG_OC_TIMING: begin
				next_rdata[FILTER_LSB +: 2] = overcurrent_filter_sel;
				next_rdata[MASK_LSB +: 2] = overcurrent_mask_sel;
				next_rdata[THRESH_POS] = overcurrent_threshold_sel;
			end
			REG_RETRY_TIMING: begin
				next_rdata[LONG_LSB +: 2] = long_recovery_interval;
				next_rdata[SHORT_LSB +: 2] = short_recovery_interval;
			end
			REG_GEN_PERIOD: next_rdata[VALUE_W-1:0] = generator_period_value;
			REG_DUTY_A: next_rdata[VALUE_W-1:0] = phase_a_duty_value;
			REG_DUTY_B: next_rdata[VALUE_W-1:0] = phase_b_duty_value;
			REG_DUTY_C: next_rdata[VALUE_W-1:0] = phase_c_duty_value;
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= seal(next_rdata, link_check_enable);
		end
	end

	oc_qualify u_qualify (
		.clk(clk),
		.rst_n(rst_n),
		.oc_level_raw(oc_level_raw),
		.switch_edge(switch_edge),
		.filter_cycles(qual_cycles(overcurrent_filter_sel)),
		.mask_cycles(qual_cycles(overcurrent_mask_sel)),
		.oc_detect(oc_detect),
		.blanking(blanking)
	);

	// Retry delay picked by response mode
	always_comb begin
		retry_load = '0;
		if (overcurrent_response_sel == RESP_LONG) begin
			case (long_recovery_interval)
				2'h0: retry_load = RETRY_W'(LONG_RETRY_C0);
				2'h1: retry_load = RETRY_W'(LONG_RETRY_C1);
				2'h2: retry_load = RETRY_W'(LONG_RETRY_C2);
				default: retry_load = RETRY_W'(LONG_RETRY_C3);
			endcase
		end else begin
			case (short_recovery_interval)
				2'h0: retry_load = RETRY_W'(SHORT_RETRY_C0);
				2'h1: retry_load = RETRY_W'(SHORT_RETRY_C1);
				2'h2: retry_load = RETRY_W'(SHORT_RETRY_C2);
				default: retry_load = RETRY_W'(SHORT_RETRY_C3);
			endcase
		end
	end

	retry_timer u_retry (
		.clk(clk),
		.rst_n(rst_n),
		.start(timer_start),
		.abort(timer_abort),
		.load_value(retry_load),
		.expired(timer_expired),
		.busy(timer_busy)
	);

	// Fault sequencer
	always_comb begin
		next_state = state;
		timer_start = 1'b0;
		timer_abort = 1'b0;
		case (state)
			FS_RUN: begin
				if (oc_detect) begin
					case (overcurrent_response_sel)
						RESP_LONG, RESP_SHORT: begin
							next_state = FS_RETRY;
							timer_start = 1'b1;
						end
						RESP_LATCH: next_state = FS_LATCHED;
						default: next_state = FS_RUN;
					endcase
				end
			end
			FS_RETRY: begin
				if (timer_expired && oc_detect)
					timer_start = 1'b1;
				else if (timer_expired)
					next_state = FS_RUN;
			end
			FS_LATCHED: begin
				if (latched_fault_wipe && !oc_detect)
					next_state = FS_RUN;
			end
			default: begin
				next_state = FS_RUN;
				timer_abort = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state <= FS_RUN;
		else
			state <= next_state;
	end

	// Sticky status; a new detection beats the wipe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			oc_fault_status <= 1'b0;
		else if (oc_detect && overcurrent_response_sel != RESP_OFF)
			oc_fault_status <= 1'b1;
		else if (latched_fault_wipe)
			oc_fault_status <= 1'b0;
		else if (state == FS_RETRY && timer_expired)
			oc_fault_status <= 1'b0;
	end

	assign outputs_hiz = (state != FS_RUN);
	assign fault_indicator_pin_n = !oc_fault_status;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_wipe_one_shot: assert property (latched_fault_wipe |=> !latched_fault_wipe)
		else $error("wipe command held");
	a_wipe_clears: assert property (latched_fault_wipe && !oc_detect |=> !oc_fault_status)
		else $error("wipe left fault set");
	a_zero_wipe: assert property (wr_ok && reg_addr == REG_FAULT_CLEAR && !reg_wdata[WIPE_POS]
		&& oc_fault_status && !latched_fault_wipe && state != FS_RETRY |=> oc_fault_status)
		else $error("zero write cleared fault");
	a_read_parity: assert property (reg_rvalid |-> reg_rdata[PARITY_POS]
		== ($past(link_check_enable) ? word_parity(reg_rdata) : 1'b0))
		else $error("read parity wrong");
	a_bad_parity_drop: assert property (wr_bad && reg_addr == REG_GEN_PERIOD
		|=> $stable(generator_period_value))
		else $error("bad parity write stored");
	a_filter_store: assert property (wr_ok && reg_addr == REG_OC_TIMING
		|=> overcurrent_filter_sel == $past(reg_wdata[FILTER_LSB +: 2])
		&& overcurrent_mask_sel == $past(reg_wdata[MASK_LSB +: 2]))
		else $error("timing fields not stored");
	a_thresh_out: assert property (wr_ok && reg_addr == REG_OC_TIMING
		|=> gen_cfg.threshold_low == $past(reg_wdata[THRESH_POS]))
		else $error("threshold not applied");
	a_retry_store: assert property (wr_ok && reg_addr == REG_RETRY_TIMING
		|=> long_recovery_interval == $past(reg_wdata[LONG_LSB +: 2])
		&& short_recovery_interval == $past(reg_wdata[SHORT_LSB +: 2]))
		else $error("retry fields not stored");
	a_short_load: assert property (timer_start && overcurrent_response_sel == RESP_SHORT
		&& short_recovery_interval == 2'h3 |-> retry_load == RETRY_W'(SHORT_RETRY_C3))
		else $error("fast retry load wrong");
	a_period_store: assert property (wr_ok && reg_addr == REG_GEN_PERIOD
		|=> gen_cfg.period == $past(reg_wdata[VALUE_W-1:0]))
		else $error("period not stored");
	a_duty_a_store: assert property (wr_ok && reg_addr == REG_DUTY_A
		|=> gen_cfg.duty_a == $past(reg_wdata[VALUE_W-1:0]))
		else $error("duty A not stored");
	a_duty_b_store: assert property (wr_ok && reg_addr == REG_DUTY_B
		|=> gen_cfg.duty_b == $past(reg_wdata[VALUE_W-1:0]))
		else $error("duty B not stored");
	a_duty_c_store: assert property (wr_ok && reg_addr == REG_DUTY_C
		|=> gen_cfg.duty_c == $past(reg_wdata[VALUE_W-1:0]))
		else $error("duty C not stored");
	a_latch_holds: assert property (state == FS_LATCHED && !latched_fault_wipe
		|=> state == FS_LATCHED && outputs_hiz)
		else $error("latched fault released");
	a_hiz_flagged: assert property (state == FS_RUN && oc_detect
		&& overcurrent_response_sel == RESP_LATCH |=> outputs_hiz && !fault_indicator_pin_n)
		else $error("latch entry not reported");
	a_mask_no_trip: assert property (blanking ##1 state == FS_RUN
		|=> state == FS_RUN)
		else $error("trip during masking");

	c_wipe: cover property (latched_fault_wipe && oc_fault_status);
	c_retry_done: cover property (state == FS_RETRY && timer_expired && !oc_detect);
	c_latched: cover property (state == FS_LATCHED);
	c_parity_bad: cover property (wr_bad);

endmodule

// file: rtl/oc_qualify.sv
// Overcurrent masking after switching edges and persistence filter
// Assumes oc_level_raw is asynchronous; switch_edge is on clk
`timescale 1ns/1ps
module oc_qualify
	import fault_timing_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Comparator and switching events
	input wire logic oc_level_raw,
	input wire logic switch_edge,
	// Selected times in cycles
	input wire logic [QUAL_W-1:0] filter_cycles,
	input wire logic [QUAL_W-1:0] mask_cycles,
	// Qualified result
	output logic oc_detect,
	output logic blanking
);

	logic sync1, sync2, sync3, oc_sync;
	logic [QUAL_W-1:0] mask_cnt, filt_cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= oc_level_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Change accepted once the last two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			oc_sync <= 1'b0;
		else if (sync2 == sync3)
			oc_sync <= sync3;
	end

	// Masking window restarts on each switching edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			mask_cnt <= '0;
		else if (switch_edge)
			mask_cnt <= mask_cycles;
		else if (mask_cnt != '0)
			mask_cnt <= mask_cnt - 1'b1;
	end

	assign blanking = switch_edge || (mask_cnt != '0);

	// Count consecutive qualified cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			filt_cnt <= '0;
		else if (blanking || !oc_sync)
			filt_cnt <= '0;
		else if (filt_cnt < filter_cycles)
			filt_cnt <= filt_cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			oc_detect <= 1'b0;
		else
			oc_detect <= !blanking && oc_sync && (filt_cnt >= filter_cycles);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_mask_blocks: assert property (blanking |=> !oc_detect)
		else $error("detect raised during masking");
	a_filter_holds: assert property ($rose(oc_detect) |-> $past(filt_cnt) >= $past(filter_cycles))
		else $error("detect before filter time");

endmodule

// file: rtl/retry_timer.sv
// Down counter timing the automatic recovery delay
// Assumes start is a single-cycle pulse on clk
`timescale 1ns/1ps
module retry_timer
	import fault_timing_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [RETRY_W-1:0] load_value,
	// Status
	output logic expired,
	output logic busy
);

	logic [RETRY_W-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			busy <= 1'b0;
		end else if (abort) begin
			count <= '0;
			busy <= 1'b0;
		end else if (start) begin
			count <= load_value;
			busy <= 1'b1;
		end else if (busy && count <= RETRY_W'(1)) begin
			count <= '0;
			busy <= 1'b0;
		end else if (busy) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			expired <= 1'b0;
		else
			expired <= busy && !abort && !start && count <= RETRY_W'(1);
	end

endmodule

// file: tb/host_word_model.sv
// Host side model issuing whole words on the register word port
// Assumes rising-edge clk; all changes 1 ns after the edge
`timescale 1ns/1ps
module host_word_model (
	// Clock
	input wire logic clk,
	// Word port
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines flip so a stale value never passes
	task automatic idle();
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		idle();
	endtask
	task automatic read(input logic [7:0] a, output logic [15:0] d,
		output logic ok);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		idle();
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the fault timing register bank
// Assumes shortened retry counts handed in as parameters
`timescale 1ns/1ps
module testbench
	import fault_timing_pkg::*;
;
	localparam int LR0 = 20;
	localparam int LR1 = 30;
	localparam int LR2 = 40;
	localparam int LR3 = 50;
	localparam int SR0 = 5;
	localparam int SR1 = 6;
	localparam int SR2 = 7;
	localparam int SR3 = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_wr, reg_rd, reg_rvalid, link_parity_error;
	logic link_check_enable = 1'b0;
	logic [2:0] overcurrent_response_sel = 3'h3;
	logic oc_level_raw = 1'b0;
	logic switch_edge = 1'b0;
	gen_cfg_s gen_cfg;
	logic outputs_hiz, fault_indicator_pin_n, oc_fault_status;
	logic [15:0] mdl [256];
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	int perr = 0;
	always #10 clk = ~clk;
	host_word_model host (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	fault_timing_regs #(.LONG_RETRY_C0(LR0), .LONG_RETRY_C1(LR1),
		.LONG_RETRY_C2(LR2), .LONG_RETRY_C3(LR3), .SHORT_RETRY_C0(SR0),
		.SHORT_RETRY_C1(SR1), .SHORT_RETRY_C2(SR2), .SHORT_RETRY_C3(SR3))
	uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.link_parity_error(link_parity_error),
		.link_check_enable(link_check_enable),
		.overcurrent_response_sel(overcurrent_response_sel),
		.oc_level_raw(oc_level_raw), .switch_edge(switch_edge),
		.gen_cfg(gen_cfg), .outputs_hiz(outputs_hiz),
		.fault_indicator_pin_n(fault_indicator_pin_n),
		.oc_fault_status(oc_fault_status));
	task automatic end_of_test();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Mid-cycle sampling so registered pulses have settled
	always @(negedge clk) begin
		cycles++;
		if (link_parity_error === 1'b1) perr++;
		if (cycles > 6000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bits that each offset stores
	function automatic logic [15:0] wmask(input logic [7:0] a);
		case (a)
			8'h13: wmask = 16'h003d;
			8'h16: wmask = 16'h000f;
			8'h18, 8'h19, 8'h1a, 8'h1b: wmask = 16'h0fff;
			default: wmask = 16'h0000;
		endcase
	endfunction
	// Expected retry delay in cycles for a mode and field code
	function automatic int retry_cyc(input bit fast, input logic [1:0] c);
		case (c)
			2'h0: retry_cyc = fast ? SR0 : LR0;
			2'h1: retry_cyc = fast ? SR1 : LR1;
			2'h2: retry_cyc = fast ? SR2 : LR2;
			default: retry_cyc = fast ? SR3 : LR3;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		if (!link_check_enable || d[15] == ^d[14:0]) mdl[a] = d & wmask(a);
		host.write(a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a);
		logic [15:0] d;
		logic [15:0] e;
		logic ok;
		e = mdl[a];
		e[15] = link_check_enable & ^e[14:0];
		host.read(a, d, ok);
		chk({15'h0, ok}, 16'h0001);
		chk(d, e);
	endtask
	task automatic cfg_chk();
		@(posedge clk);
		#1;
		chk({15'h0, gen_cfg.threshold_low}, {15'h0, mdl[8'h13][0]});
		chk({4'h0, gen_cfg.period}, mdl[8'h18]);
		chk({4'h0, gen_cfg.duty_a}, mdl[8'h19]);
		chk({4'h0, gen_cfg.duty_b}, mdl[8'h1a]);
		chk({4'h0, gen_cfg.duty_c}, mdl[8'h1b]);
	endtask
	task automatic wait_st(input logic v, input int lim, output int n);
		n = 0;
		while (oc_fault_status !== v && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	// Comparator held high for len cycles, optionally with an edge in its first cycle
	task automatic oc_for(input int len, input logic edge_first);
		@(posedge clk);
		#1;
		switch_edge = edge_first;
		oc_level_raw = 1'b1;
		@(posedge clk);
		#1;
		switch_edge = 1'b0;
		repeat (len - 1) @(posedge clk);
		#1;
		oc_level_raw = 1'b0;
		repeat (70) @(posedge clk);
		#1;
	endtask
	task automatic wipe();
		wr(8'h17, 16'h0001);
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		logic [15:0] d;
		int n, i, st, p;
		logic [7:0] addrs [8];
		addrs = '{8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
		d = 16'($urandom(32'h6d48a49a));
		foreach (mdl[k]) mdl[k] = 16'h0000;
		mdl[8'h13] = 16'h0030;
		mdl[8'h16] = 16'h0003;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk({14'h0, outputs_hiz, fault_indicator_pin_n}, 16'h0001);
		foreach (addrs[k]) rd_chk(addrs[k]);
		for (i = 0; i < 40; i++) begin
			link_check_enable = 1'($urandom);
			d = 16'($urandom);
			if (i % 3 == 0) d[15] = ^d[14:0];
			wr(addrs[i % 8], d);
			rd_chk(addrs[3'($urandom)]);
			cfg_chk();
		end
		link_check_enable = 1'b1;
		st = perr;
		d = 16'h0123;
		d[15] = ~^d[14:0];
		wr(8'h18, d);
		repeat (2) @(posedge clk);
		#1;
		chk(16'(perr - st), 16'h0001);
		rd_chk(8'h18);
		link_check_enable = 1'b0;
		wr(8'h13, 16'h0030);
		oc_for(30, 1'b0);
		chk({15'h0, oc_fault_status}, 16'h0000);
		oc_for(80, 1'b0);
		chk({14'h0, oc_fault_status, outputs_hiz}, 16'h0002);
		wipe();
		wr(8'h13, 16'h000c);
		oc_for(30, 1'b1);
		chk({15'h0, oc_fault_status}, 16'h0000);
		oc_for(30, 1'b0);
		chk({15'h0, oc_fault_status}, 16'h0001);
		wipe();
		overcurrent_response_sel = 3'h2;
		oc_level_raw = 1'b1;
		wait_st(1'b1, 100, n);
		@(posedge clk);
		#1;
		chk({13'h0, oc_fault_status, fault_indicator_pin_n, outputs_hiz},
			16'h0005);
		oc_level_raw = 1'b0;
		repeat (30) @(posedge clk);
		#1;
		wr(8'h17, 16'h0000);
		repeat (3) @(posedge clk);
		#1;
		chk({15'h0, oc_fault_status}, 16'h0001);
		wipe();
		chk({14'h0, oc_fault_status, outputs_hiz}, 16'h0000);
		for (i = 0; i < 4; i++) begin
			wr(8'h16, {12'h000, 4'($urandom)});
			p = retry_cyc(i[0], i[0] ? mdl[8'h16][1:0] : mdl[8'h16][3:2]);
			overcurrent_response_sel = 3'(i % 2);
			oc_level_raw = 1'b1;
			wait_st(1'b1, 100, n);
			oc_level_raw = 1'b0;
			@(posedge clk);
			#1;
			chk({15'h0, outputs_hiz}, 16'h0001);
			wait_st(1'b0, 200, n);
			chk(16'(n + 2 >= p && n <= p + 6), 16'h0001);
		end
		overcurrent_response_sel = 3'h7;
		oc_for(30, 1'b0);
		chk({14'h0, oc_fault_status, outputs_hiz}, 16'h0000);
		end_of_test();
	end
endmodule
